// ### verilog/sfu_top.sv
module sfu_top
  import sfu_pkg::*;
(
  input  wire logic        hclk,      // Bus clock.
  input  wire logic        hresetn,   // Asynchronous reset, low active.
  input  wire logic        ce,        // Clock enable; low freezes all state.
  input  wire logic        hsel,      // AHB slave select.
  input  wire logic [7:0]  haddr,     // AHB address.
  input  wire logic [1:0]  htrans,    // AHB transfer type.
  input  wire logic        hwrite,    // AHB write.
  input  wire logic [2:0]  hsize,     // AHB size.
  input  wire logic        hready,    // AHB ready in.
  input  wire logic [31:0] hwdata,    // AHB write data.
  output logic [31:0]      hrdata,    // AHB read data.
  output logic             hreadyout, // AHB ready out.
  output logic             hresp,     // AHB response, always OKAY.
  input  wire logic        rxd,       // Serial input pin.
  output logic             txd,       // Serial output pin.
  output logic             irq        // Level interrupt.
);

  typedef enum logic [4:0] {
    SFU_T_IDLE  = 5'b00001,
    SFU_T_START = 5'b00010,
    SFU_T_DATA  = 5'b00100,
    SFU_T_PAR   = 5'b01000,
    SFU_T_STOP  = 5'b10000
  } sfu_tst_t;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers.

  sfu_frame_t   frame_q;
  logic [1:0]   eol_mode_q;
  logic         eol_two_q;
  logic [15:0]  div_q;
  logic [7:0]   eol_first_char_q;
  logic [7:0]   eol_second_char_q;
  logic [SFU_NIRQ-1:0] ist_q, imask_q, iset;
  logic         wr_ph_q;
  logic [7:0]   ad_q;
  logic         txq_v_q;
  logic [7:0]   txq_q;
  logic         rxb_v_q;
  logic [7:0]   rxb_q;
  logic         tx_busy;
  logic         tx_take;
  logic [31:0]  rd_val;
  logic         acc;

  assign acc = hsel & hready & htrans[1];

  // Address phase capture; the slave never inserts wait states. Read data is
  // registered here so that it stands through the data phase straight from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q   <= 1'b0;
      hrdata    <= 32'h0;
      ad_q      <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      if (hready) begin
        wr_ph_q <= acc & hwrite;
        hrdata  <= (acc && !hwrite) ? rd_val : 32'h0;
        ad_q    <= haddr;
      end
    end
  end

  // Software writes; configuration is only meant to change while idle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_q           <= '0;
      eol_mode_q        <= SFU_EOL_PASS;
      eol_two_q         <= 1'b1;
      div_q             <= SFU_DIV_RST;
      eol_first_char_q  <= SFU_CR;
      eol_second_char_q <= SFU_LF;
      imask_q           <= '0;
    end else if (ce && wr_ph_q) begin
      case (ad_q)
        SFU_ADDR_CTRL: begin
          frame_q    <= hwdata[4:0];                // [R04] [R08] [R09]
          eol_mode_q <= hwdata[6:5];
          eol_two_q  <= hwdata[7];
        end
        SFU_ADDR_DIV:  div_q             <= hwdata[15:0]; // [R02]
        SFU_ADDR_EOL1: eol_first_char_q  <= hwdata[7:0];  // [R13]
        SFU_ADDR_EOL2: eol_second_char_q <= hwdata[7:0];  // [R13]
        SFU_ADDR_MASK: imask_q           <= hwdata[SFU_NIRQ-1:0];
        default: ;
      endcase
    end
  end

  // Read mux on the address phase; unmapped addresses read zero.
  always_comb begin
    case (haddr)
      SFU_ADDR_CTRL: rd_val = {24'h0, eol_two_q, eol_mode_q, frame_q};
      SFU_ADDR_DIV:  rd_val = {16'h0, div_q};
      SFU_ADDR_EOL1: rd_val = {24'h0, eol_first_char_q};
      SFU_ADDR_EOL2: rd_val = {24'h0, eol_second_char_q};
      SFU_ADDR_RXD:  rd_val = {24'h0, rxb_q};
      SFU_ADDR_STAT: rd_val = {29'h0, tx_busy, txq_v_q, rxb_v_q};
      SFU_ADDR_IRQ:  rd_val = {27'h0, ist_q};
      SFU_ADDR_MASK: rd_val = {27'h0, imask_q};
      default:       rd_val = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate tick and input synchroniser.

  logic [15:0] bdiv_q;
  logic        tick_q;
  logic [1:0]  rx_sync_q;

  // One tick per sixteenth of a bit, shared by both directions.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bdiv_q <= 16'h0;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= (bdiv_q == 16'h0);                 // [R02]
      bdiv_q <= (bdiv_q == 16'h0) ? div_q : bdiv_q - 16'h1;
    end
  end

  // Two flops before any logic reads the pin; idle line reads as one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rx_sync_q <= 2'b11;
    else if (ce) rx_sync_q <= {rx_sync_q[0], rxd};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver and receive holding byte.

  sfu_rxev_t rx_ev;

  sfu_rx u_rx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .tick    (tick_q),
    .rxd     (rx_sync_q[1]),
    .cfg     (frame_q),
    .ev      (rx_ev)
  );

  // A good character is held; a framing error discards it. Reading empties it at
  // the address phase, so a character landing on that same edge is kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxb_v_q <= 1'b0;
      rxb_q   <= 8'h00;
    end else if (ce) begin
      if (rx_ev.valid && !rx_ev.ferr) begin     // [R10]
        rxb_v_q <= 1'b1;
        rxb_q   <= rx_ev.data;
      end else if (acc && !hwrite && haddr == SFU_ADDR_RXD) begin
        rxb_v_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // End-of-line filter on the transmit path.

  logic       pend_q;     // First EOL char seen, held back.
  logic       ins2_q;     // Second inserted char owed.
  logic       wr_tx;
  logic [7:0] wdat;

  assign wr_tx = wr_ph_q & (ad_q == SFU_ADDR_TXD);
  assign wdat  = hwdata[7:0];

  // One-byte transmit holding register fed by the filter. A write while the
  // holder is full is dropped and flagged; software polls the ready bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txq_v_q <= 1'b0;
      txq_q   <= 8'h00;
      pend_q  <= 1'b0;
      ins2_q  <= 1'b0;
    end else if (ce) begin
      if (tx_take) txq_v_q <= 1'b0;
      if (ins2_q && (!txq_v_q || tx_take)) begin
        txq_v_q <= 1'b1;                           // [R12]
        txq_q   <= eol_second_char_q;
        ins2_q  <= 1'b0;
      end else if (wr_tx && (!txq_v_q || tx_take)) begin
        case (eol_mode_q)
          SFU_EOL_PASS: begin
            txq_v_q <= 1'b1;
            txq_q   <= wdat;
          end
          SFU_EOL_INS: begin
            txq_v_q <= 1'b1;
            txq_q   <= wdat;
            ins2_q  <= (wdat == eol_first_char_q) & eol_two_q; // [R12]
          end
          default: begin
            // Delete or replace: match the sequence, hold its first char.
            if (!pend_q && wdat == eol_first_char_q && eol_two_q) begin
              pend_q <= 1'b1;                      // [R11]
            end else if (pend_q && wdat == eol_second_char_q) begin
              pend_q <= 1'b0;                      // [R11]
              if (eol_mode_q == SFU_EOL_REPL) begin
                txq_v_q <= 1'b1;
                txq_q   <= SFU_CR;                 // Replacement sequence.
                ins2_q  <= 1'b1;
              end
            end else if (!eol_two_q && wdat == eol_first_char_q) begin
              if (eol_mode_q == SFU_EOL_REPL) begin
                txq_v_q <= 1'b1;                   // [R11]
                txq_q   <= SFU_CR;
              end
            end else begin
              // A broken match forwards the plain character only.
              pend_q  <= 1'b0;
              txq_v_q <= 1'b1;
              txq_q   <= wdat;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  sfu_tst_t   ts_q;
  logic [3:0] tos_q;
  logic [2:0] tbit_q;
  logic [7:0] tsh_q;
  logic       tpar_q;
  logic       tstop2_q;
  logic       pbit;

  assign tx_busy = (ts_q != SFU_T_IDLE);
  assign tx_take = txq_v_q & ~tx_busy;

  // Parity bit from the data ones count or a forced constant.
  always_comb begin
    case (frame_q.parity)
      SFU_PAR_ODD:  pbit = ~tpar_q;                // [R05]
      SFU_PAR_EVEN: pbit = tpar_q;                 // [R06]
      SFU_PAR_ONE:  pbit = 1'b1;                   // [R07]
      default:      pbit = 1'b0;                   // [R07]
    endcase
  end

  // Bit sequencer; each bit lasts sixteen ticks.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_q     <= SFU_T_IDLE;
      tos_q    <= 4'h0;
      tbit_q   <= 3'h0;
      tsh_q    <= 8'h00;
      tpar_q   <= 1'b0;
      tstop2_q <= 1'b0;
      txd      <= 1'b1;
    end else if (ce) begin
      if (ts_q == SFU_T_IDLE) begin
        txd <= 1'b1;                               // [R01]
        if (tx_take) begin
          tsh_q    <= txq_q;
          tpar_q   <= ^(frame_q.word8 ? txq_q : {1'b0, txq_q[6:0]});
          tstop2_q <= frame_q.two_stop;
          tos_q    <= 4'h0;
          ts_q     <= SFU_T_START;
        end
      end else if (tick_q) begin
        tos_q <= tos_q + 4'h1;
        case (ts_q)
          SFU_T_START: begin
            txd <= 1'b0;                           // [R03]
            if (tos_q == SFU_OVS) begin
              tbit_q <= 3'h0;
              ts_q   <= SFU_T_DATA;
            end
          end
          SFU_T_DATA: begin
            txd <= tsh_q[tbit_q];                  // [R15]
            if (tos_q == SFU_OVS) begin
              tbit_q <= tbit_q + 3'h1;
              if (tbit_q == (frame_q.word8 ? 3'h7 : 3'h6)) begin // [R04]
                ts_q <= (frame_q.parity == SFU_PAR_NONE) ? SFU_T_STOP : SFU_T_PAR; // [R08]
              end
            end
          end
          SFU_T_PAR: begin
            txd <= pbit;                           // [R15]
            if (tos_q == SFU_OVS) ts_q <= SFU_T_STOP;
          end
          SFU_T_STOP: begin
            txd <= 1'b1;                           // [R08]
            if (tos_q == SFU_OVS) begin
              if (tstop2_q) tstop2_q <= 1'b0;
              else ts_q <= SFU_T_IDLE;
            end
          end
          default: ts_q <= SFU_T_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins over clear.

  assign iset[SFU_IRQ_RXRDY] = rx_ev.valid & ~rx_ev.ferr;
  assign iset[SFU_IRQ_TXRDY] = tx_take;
  assign iset[SFU_IRQ_PERR]  = rx_ev.valid & rx_ev.perr;
  assign iset[SFU_IRQ_FERR]  = rx_ev.valid & rx_ev.ferr;
  assign iset[SFU_IRQ_OVR]   = (rx_ev.valid & ~rx_ev.ferr & rxb_v_q) | (wr_tx & txq_v_q & ~tx_take);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= '0;
      irq   <= 1'b0;
    end else if (ce) begin
      ist_q <= (ist_q & ~((wr_ph_q && ad_q == SFU_ADDR_IRQ) ? hwdata[SFU_NIRQ-1:0] : '0)) | iset;
      irq   <= |(ist_q & imask_q);
    end
  end

endmodule // sfu_top

// ### verilog/sfu_pkg.sv
// Summary of operation
// [R01] The transmit line idles at one whenever no frame is being sent.
// [R02] Transmitter and receiver share one software-set bit-rate divisor that must match the far end.
// [R03] Every frame opens with exactly one start bit, then the data bits, then stop bits.
// [R04] Frame length is start plus seven or eight data bits plus optional parity plus one or two stops.
// [R05] Odd parity makes the parity bit zero when the data ones are odd and one when they are even.
// [R06] Even parity makes the count of ones even, and a received odd count is a parity error.
// [R07] Parity may instead be forced to a constant one or a constant zero.
// [R08] Parity may be omitted; one stop bit is always sent and two may be chosen.
// [R09] Both ends must use the same parity, word size and stop count for frames to be read alike.
// [R10] A received frame whose stop bits are missing at their place is dropped, not stored.
// [R11] End-of-line sequences in the stream are recognised and either deleted or replaced.
// [R12] Toward the serial side an end-of-line sequence of one or two characters can be inserted.
// [R13] The end-of-line sequence is held in two dedicated character registers.
// [R14] The receiver oversamples, checks the start bit at mid-bit and shifts data in LSB first.
// [R15] The transmitter sends data LSB first, then parity if on, then stop bits, each one bit long.
package sfu_pkg;

  // Register byte offsets.
  localparam logic [7:0] SFU_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SFU_ADDR_DIV  = 8'h04;
  localparam logic [7:0] SFU_ADDR_EOL1 = 8'h08;
  localparam logic [7:0] SFU_ADDR_EOL2 = 8'h0C;
  localparam logic [7:0] SFU_ADDR_TXD  = 8'h10;
  localparam logic [7:0] SFU_ADDR_RXD  = 8'h14;
  localparam logic [7:0] SFU_ADDR_STAT = 8'h18;
  localparam logic [7:0] SFU_ADDR_IRQ  = 8'h1C;
  localparam logic [7:0] SFU_ADDR_MASK = 8'h20;

  // Parity modes.
  localparam logic [2:0] SFU_PAR_NONE = 3'h0;
  localparam logic [2:0] SFU_PAR_ODD  = 3'h1;
  localparam logic [2:0] SFU_PAR_EVEN = 3'h2;
  localparam logic [2:0] SFU_PAR_ONE  = 3'h3;
  localparam logic [2:0] SFU_PAR_ZERO = 3'h4;

  // End-of-line handling modes.
  localparam logic [1:0] SFU_EOL_PASS = 2'h0;
  localparam logic [1:0] SFU_EOL_DEL  = 2'h1;
  localparam logic [1:0] SFU_EOL_REPL = 2'h2;
  localparam logic [1:0] SFU_EOL_INS  = 2'h3;

  // Interrupt status bit positions.
  localparam int SFU_IRQ_RXRDY = 0;
  localparam int SFU_IRQ_TXRDY = 1;
  localparam int SFU_IRQ_PERR  = 2;
  localparam int SFU_IRQ_FERR  = 3;
  localparam int SFU_IRQ_OVR   = 4;
  localparam int SFU_NIRQ      = 5;

  localparam logic [15:0] SFU_DIV_RST = 16'h000D;
  localparam logic [7:0]  SFU_CR      = 8'h0D;
  localparam logic [7:0]  SFU_LF      = 8'h0A;
  localparam logic [3:0]  SFU_OVS     = 4'hF;   // Sixteen ticks per bit, minus one.
  localparam logic [3:0]  SFU_MID     = 4'h7;

  // Frame configuration shared by the top and the receiver.
  typedef struct packed {
    logic       two_stop;
    logic       word8;
    logic [2:0] parity;
  } sfu_frame_t;

  // Received character event.
  typedef struct packed {
    logic       valid;
    logic       perr;
    logic       ferr;
    logic [7:0] data;
  } sfu_rxev_t;

endpackage : sfu_pkg

// ### verilog/sfu_rx.sv
module sfu_rx
  import sfu_pkg::*;
(
  input  wire logic       hclk,    // Bus clock.
  input  wire logic       hresetn, // Asynchronous reset, low active.
  input  wire logic       ce,      // Clock enable.
  input  wire logic       tick,    // Oversample tick.
  input  wire logic       rxd,     // Synchronised serial input.
  input  wire sfu_frame_t cfg,     // Frame setup.
  output sfu_rxev_t       ev       // One-cycle character event.
);

  typedef enum logic [4:0] {
    SFU_R_IDLE  = 5'b00001,
    SFU_R_START = 5'b00010,
    SFU_R_DATA  = 5'b00100,
    SFU_R_PAR   = 5'b01000,
    SFU_R_STOP  = 5'b10000
  } sfu_rst_t;

  sfu_rst_t   st_q;
  logic [3:0] os_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic       pbit_q;
  logic       stop2_q;
  logic       pok;
  logic       ones;

  // Data ones parity; word7 ignores sh_q bit 0.
  assign ones = ^(cfg.word8 ? sh_q : {1'b0, sh_q[7:1]});

  // Even wants total even, odd wants odd; forced modes compare a constant.
  always_comb begin
    case (cfg.parity)
      SFU_PAR_EVEN: pok = ~(ones ^ pbit_q);     // [R06]
      SFU_PAR_ODD:  pok = ones ^ pbit_q;        // [R05]
      SFU_PAR_ONE:  pok = pbit_q;               // [R07]
      SFU_PAR_ZERO: pok = ~pbit_q;              // [R07]
      default:      pok = 1'b1;
    endcase
  end

  // Sampling state machine; every bit is taken at its middle tick.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= SFU_R_IDLE;
      os_q    <= 4'h0;
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      pbit_q  <= 1'b0;
      stop2_q <= 1'b0;
      ev      <= '0;
    end else if (ce) begin
      ev.valid <= 1'b0;
      if (tick) begin
        os_q <= os_q + 4'h1;
        case (st_q)
          SFU_R_IDLE: begin
            os_q <= 4'h0;
            if (!rxd) st_q <= SFU_R_START;
          end
          SFU_R_START: begin
            if (os_q == SFU_MID) begin
              os_q  <= 4'h0;                   // [R14]
              bit_q <= 3'h0;
              st_q  <= rxd ? SFU_R_IDLE : SFU_R_DATA; // [R14]
            end
          end
          SFU_R_DATA: begin
            if (os_q == SFU_OVS) begin
              sh_q <= {rxd, sh_q[7:1]};        // [R14]
              bit_q <= bit_q + 3'h1;
              if (bit_q == (cfg.word8 ? 3'h7 : 3'h6)) begin // [R04]
                st_q    <= (cfg.parity == SFU_PAR_NONE) ? SFU_R_STOP : SFU_R_PAR; // [R08]
                stop2_q <= cfg.two_stop;
              end
            end
          end
          SFU_R_PAR: begin
            if (os_q == SFU_OVS) begin
              pbit_q <= rxd;
              st_q   <= SFU_R_STOP;
            end
          end
          SFU_R_STOP: begin
            if (os_q == SFU_OVS) begin
              if (!rxd || !stop2_q) begin
                // A missing stop bit ends the frame as a framing error.
                ev.valid <= 1'b1;
                ev.ferr  <= ~rxd;              // [R10]
                ev.perr  <= (cfg.parity != SFU_PAR_NONE) & ~pok;
                ev.data  <= cfg.word8 ? sh_q : {1'b0, sh_q[7:1]};
                st_q     <= SFU_R_IDLE;
              end
              stop2_q <= 1'b0;
            end
          end
          default: st_q <= SFU_R_IDLE;
        endcase
      end
    end
  end

endmodule // sfu_rx

// ### verification/sfu_monitor.sv
module sfu_monitor
  import sfu_pkg::*;
(
  input wire logic        hclk,      // Bus clock.
  input wire logic        hresetn,   // Asynchronous reset, low active.
  input wire logic        hsel,      // Slave select.
  input wire logic [7:0]  haddr,     // Address.
  input wire logic [1:0]  htrans,    // Transfer type.
  input wire logic        hwrite,    // Write.
  input wire logic        hready,    // Ready in.
  input wire logic [31:0] hrdata,    // Read data.
  input wire logic        hreadyout, // Ready out.
  input wire logic        hresp,     // Response.
  input wire logic        txd,       // Serial output.
  input wire logic        irq        // Interrupt.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic aph;
  logic txw_q;
  assign aph = hsel && hready && htrans[1];

  // Remembers a transmit write, since a frame may only start after one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txw_q <= 1'b0;
    end else if (aph && hwrite && haddr == SFU_ADDR_TXD) begin
      txw_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  idle_after_reset_a: assert property ($rose(hresetn) |-> txd)
    else $error("txd not idle after reset");
  tx_cause_a: assert property ($fell(txd) |-> txw_q)
    else $error("frame started with nothing written");
  start_len_a: assert property ($fell(txd) |=> !txd [*8])
    else $error("start bit too short");
  bit_len_a: assert property ($rose(txd) |=> txd [*8])
    else $error("one bit too short");
  irq_clear_a: assert property ($fell(irq) |->
      $past(aph && hwrite && (haddr == SFU_ADDR_IRQ || haddr == SFU_ADDR_MASK), 3))
    else $error("irq fell without a clear or mask write");
  okay_resp_a: assert property (!hresp)
    else $error("response not okay");
  ready_out_a: assert property (hreadyout)
    else $error("wait state inserted");
  unmapped_zero_a: assert property (aph && !hwrite && haddr > SFU_ADDR_MASK |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // sfu_monitor

bind sfu_top sfu_monitor sfu_monitor_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .txd, .irq);

// ### verification/sfu_term.sv
module sfu_term
(
  input  wire logic hclk, // Time base for bit periods.
  input  wire logic txd,  // Line from the device.
  output logic      rxd   // Line toward the device.
);
  timeunit 1ns;
  timeprecision 1ps;
  int         nb   = 8;   // Word size, set by setcfg to match the device.
  int         st   = 1;   // Stop bits.
  int         bitc = 224; // Clocks per bit, matched to the divisor.
  logic [2:0] pm   = 3'h0;
  logic [7:0] q_d[$];
  logic       q_p[$];
  logic       q_s[$];

  // Parity of the data bits that the frame actually carries.
  function automatic logic parbit(input logic [7:0] d);
    logic x;
    x = (nb == 8) ? ^d : ^d[6:0];
    case (pm)
      3'h1:    parbit = ~x;
      3'h2:    parbit = x;
      3'h3:    parbit = 1'b1;
      default: parbit = 1'b0;
    endcase
  endfunction

  // Sends one frame; a broken parity or stop bit is only made on request.
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    rxd <= 1'b0;
    repeat (bitc) @(posedge hclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (bitc) @(posedge hclk);
    end
    if (pm != 3'h0) begin
      rxd <= parbit(d) ^ bad_par;
      repeat (bitc) @(posedge hclk);
    end
    rxd <= !bad_stop;
    repeat (bitc * st) @(posedge hclk);
    rxd <= 1'b1;
    repeat (bitc) @(posedge hclk);
  endtask

  initial begin
    rxd = 1'b1;
  end

  // Samples each device frame at mid-bit with the agreed format.
  initial begin
    logic [7:0] d;
    logic       p;
    logic       s;
    forever begin
      @(negedge txd);
      repeat (bitc / 2) @(posedge hclk);
      if (txd == 1'b0) begin
        d = 8'h00;
        p = 1'b1;
        s = 1'b1;
        for (int i = 0; i < nb; i++) begin
          repeat (bitc) @(posedge hclk);
          d[i] = txd;
        end
        if (pm != 3'h0) begin
          repeat (bitc) @(posedge hclk);
          p = txd;
        end
        for (int i = 0; i < st; i++) begin
          repeat (bitc) @(posedge hclk);
          s = s & txd;
        end
        q_d.push_back(d);
        q_p.push_back(p);
        q_s.push_back(s);
      end
    end
  end
endmodule // sfu_term

// ### verification/tb.sv
module tb
  import sfu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, rxd, txd, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  int          n_mismatch, n_compared;
  logic [7:0]  dv [5] = '{8'hB3, 8'hEC, 8'hF0, 8'h01, 8'h7E};

  sfu_top sfu_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd), .irq(irq));
  sfu_term sfu_term_i (.hclk(hclk), .txd(txd), .rxd(rxd));

  always #20 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; the master never assumes how soon ready comes.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask

  // Writes a byte, then waits until the holder has been taken.
  task automatic tx(input logic [7:0] d);
    logic [31:0] r;
    wr(SFU_ADDR_TXD, {24'h0, d});
    for (int i = 0; i < 2000; i++) begin
      bus(1'b0, SFU_ADDR_STAT, 32'h0, r);
      if (r[1] == 1'b0) break;
    end
    chk("tx taken", 32'h0, {31'h0, r[1]});
  endtask

  // Checks the next frame seen on the line; the format must match the partner.
  task automatic frm(input logic [7:0] e);
    logic exp_p;
    for (int i = 0; i < 6000 && sfu_term_i.q_d.size() == 0; i++) @(posedge hclk);
    exp_p = (sfu_term_i.pm == 3'h0) ? 1'b1 : sfu_term_i.parbit(e);
    if (sfu_term_i.q_d.size() == 0) begin
      chk("tx frame", 32'h1, 32'h0);
    end else begin
      chk("tx data", {24'h0, e}, {24'h0, sfu_term_i.q_d.pop_front()});
      chk("tx parity", {31'h0, exp_p}, {31'h0, sfu_term_i.q_p.pop_front()});
      chk("tx stop", 32'h1, {31'h0, sfu_term_i.q_s.pop_front()});
    end
  endtask

  task automatic setcfg(input logic [2:0] hi, input logic s2, input logic w8, input logic [2:0] pm);
    wr(SFU_ADDR_CTRL, {24'h0, hi, s2, w8, pm});
    sfu_term_i.pm = pm;
    sfu_term_i.nb = w8 ? 8 : 7;
    sfu_term_i.st = s2 ? 2 : 1;
  endtask

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well beyond the expected run of some 6000 cycles.
  initial begin
    repeat (80000) @(posedge hclk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctrl", SFU_ADDR_CTRL, 32'h80);
    rd("div", SFU_ADDR_DIV, 32'h0D);
    rd("eol1", SFU_ADDR_EOL1, 32'h0D);
    rd("eol2", SFU_ADDR_EOL2, 32'h0A);
    rd("mask", SFU_ADDR_MASK, 32'h0);
    rd("stat", SFU_ADDR_STAT, 32'h0);
    wr(8'h24, 32'hFFFFFFFF);
    rd("unmapped", 8'h24, 32'h0);
    wr(SFU_ADDR_DIV, 32'h1);
    sfu_term_i.bitc = 32;
    wr(SFU_ADDR_MASK, 32'h1F);
    // Every parity mode, both word sizes and both stop counts.
    for (int m = 0; m < 5; m++) begin
      setcfg(3'h4, m[0], m != 1, m[2:0]);
      tx(dv[m]);
      frm((m == 1) ? (dv[m] & 8'h7F) : dv[m]);
    end
    rd("irq tx", SFU_ADDR_IRQ, 32'h2);
    chk("irq pin", 32'h1, {31'h0, irq});
    wr(SFU_ADDR_IRQ, 32'h1F);
    rd("irq clr", SFU_ADDR_IRQ, 32'h0);
    chk("irq pin", 32'h0, {31'h0, irq});
    // Receive: good frame, mask, bad parity, then a missing stop bit.
    setcfg(3'h4, 1'b0, 1'b1, SFU_PAR_EVEN);
    sfu_term_i.send(8'h96, 1'b0, 1'b0);
    rd("rx data", SFU_ADDR_RXD, 32'h96);
    rd("irq rx", SFU_ADDR_IRQ, 32'h1);
    chk("irq pin", 32'h1, {31'h0, irq});
    wr(SFU_ADDR_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(SFU_ADDR_MASK, 32'h1F);
    wr(SFU_ADDR_IRQ, 32'h1F);
    sfu_term_i.send(8'h3C, 1'b1, 1'b0);
    rd("irq perr", SFU_ADDR_IRQ, 32'h5);
    rd("rx perr data", SFU_ADDR_RXD, 32'h3C);
    wr(SFU_ADDR_IRQ, 32'h1F);
    sfu_term_i.send(8'h55, 1'b0, 1'b1);
    rd("irq ferr", SFU_ADDR_IRQ, 32'h8);
    rd("stat ferr", SFU_ADDR_STAT, 32'h0);
    // End-of-line insert, delete, replace and single-character delete.
    setcfg(3'h7, 1'b0, 1'b1, SFU_PAR_NONE);
    tx(8'h0D);
    frm(8'h0D);
    frm(8'h0A);
    setcfg(3'h5, 1'b0, 1'b1, SFU_PAR_NONE);
    tx(8'h0D);
    tx(8'h0A);
    tx(8'h41);
    frm(8'h41);
    repeat (600) @(posedge hclk);
    chk("extra frames", 32'h0, sfu_term_i.q_d.size());
    wr(SFU_ADDR_EOL1, 32'h1E);
    wr(SFU_ADDR_EOL2, 32'h1F);
    rd("eol1 rw", SFU_ADDR_EOL1, 32'h1E);
    setcfg(3'h6, 1'b0, 1'b1, SFU_PAR_NONE);
    tx(8'h1E);
    tx(8'h1F);
    frm(8'h0D);
    frm(8'h1F);
    setcfg(3'h1, 1'b0, 1'b1, SFU_PAR_NONE);
    tx(8'h1E);
    tx(8'h42);
    frm(8'h42);
    end_sim;
  end
endmodule // tb
